// *** psu_host_model.sv ***
// partner: host controller and shared bus
`timescale 1ns/1ps
module psu_host_model (
    // requests from the bench
    input  wire logic       want_on,
    input  wire logic       seated,
    input  wire logic [2:0] sel,
    input  wire logic       host_scl_low,
    // device pins
    input  wire logic       present_n,
    input  wire logic       scl_out,
    input  wire logic       scl_oe,
    input  wire logic       sda_out,
    input  wire logic       sda_oe,
    output logic            main_output_on_n,
    output logic            hot_extract_disable,
    output logic [2:0]      addr_select,
    output logic            scl_in,
    output logic            sda_in,
    // host view
    output logic            sees_module
);
    // open line reads high
    assign main_output_on_n    = !want_on;
    // short pin opens first
    assign hot_extract_disable = !seated;
    assign addr_select         = sel;
    assign sees_module         = !present_n;
    // wired-and: released line reads high
    assign scl_in = !(host_scl_low | (scl_oe & !scl_out));
    assign sda_in = !(sda_oe & !sda_out);
endmodule // psu_host_model

// *** psu_pkg.sv ***
// package: constants and types of the supply signalling
package psu_pkg;

    // clock and timing
    localparam int CLK_KHZ       = 20000;
    localparam int DEBOUNCE_US   = 100;
    localparam int DEBOUNCE_CYC  = (DEBOUNCE_US * CLK_KHZ + 999) / 1000;
    localparam int PREWARN_MS    = 2;
    localparam int PREWARN_CYC   = PREWARN_MS * CLK_KHZ;
    localparam int DEB_W         = 12;
    localparam int PREWARN_W     = 17;

    // fault status width
    localparam int FAULT_W       = 8;

    // register byte offsets
    localparam logic [7:0] REG_FAULT_STATUS = 8'h00;
    localparam logic [7:0] REG_CONTROL      = 8'h04;
    localparam logic [7:0] REG_ALERT_MASK   = 8'h08;
    localparam logic [7:0] REG_PIN_STATE    = 8'h0C;
    localparam logic [7:0] REG_IRQ_STATUS   = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK     = 8'h14;
    localparam logic [7:0] REG_BUS_ADDR     = 8'h18;

    // control register fields
    localparam int CTRL_CLEAR_FAULTS = 0;

    // interrupt status fields
    localparam int IRQ_W            = 4;
    localparam int IRQ_FAULT        = 0;
    localparam int IRQ_PGOOD_LOST   = 1;
    localparam int IRQ_INPUT_LOST   = 2;
    localparam int IRQ_ONOFF_CYCLE  = 3;

    // reset values
    localparam logic [FAULT_W-1:0] ALERT_MASK_RST = 8'h00;
    localparam logic [IRQ_W-1:0]   IRQ_MASK_RST   = 4'h0;

    // bus address base
    localparam logic [6:0] BUS_ADDR_BASE = 7'h58;

    // ahb transfer types
    localparam logic [1:0] HTRANS_IDLE   = 2'b00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    // power good sequencing
    typedef enum logic [1:0] {
        PG_OFF  = 2'b00,
        PG_ON   = 2'b01,
        PG_HOLD = 2'b10
    } psu_pg_state_t;

    // internal supply monitors
    typedef struct packed {
        logic main_valid;
        logic standby_valid;
        logic input_present;
        logic module_powered;
    } psu_monitor_t;

    // latched ahb address phase
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
    } psu_ahb_phase_t;

endpackage

// *** psu_status_control.sv ***
// top: status and control signalling of a hot-swap supply, ahb-lite registers
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps

// Function
// - power good high only while both outputs valid
// - main output off unless kill input held low
// - alert low while any unmasked fault latched
// - fault clears only after condition gone
// - alert mask blocks masked faults from alert
// - fault led follows alert output state
// - presence output tied to signal ground
// - main output on while on/off and kill inputs low and input present
// - on/off input cycle clears latched faults
// - bus address derived from select input level
// - isolate management bus while module unpowered
// - input good drops 2ms before power good
module psu_status_control #(
    parameter int PREWARN_CYCLES = psu_pkg::PREWARN_CYC
) (
    // clock and reset
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    // ahb-lite slave
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic                               hreadyout,
    output logic                               hresp,
    output logic [31:0]                        hrdata,
    // interrupt
    output logic                               irq,
    // supply monitors and fault conditions
    input  wire psu_pkg::psu_monitor_t         monitor,
    input  wire logic [psu_pkg::FAULT_W-1:0]   fault_cond,
    // host side control inputs
    input  wire logic                          main_output_on_n,
    input  wire logic                          hot_extract_disable,
    input  wire logic [2:0]                    addr_select,
    // host side status outputs
    output logic                               output_power_good,
    output logic                               output_power_good_oe,
    output logic                               input_good,
    output logic                               alert_n,
    output logic                               fault_led,
    output logic                               present_n,
    output logic                               main_output_enable,
    output logic [6:0]                         bus_addr,
    // management bus, system side pins
    input  wire logic                          scl_in,
    output logic                               scl_out,
    output logic                               scl_oe,
    input  wire logic                          sda_in,
    output logic                               sda_out,
    output logic                               sda_oe,
    // management bus, internal side
    input  wire logic                          int_scl_drive_low,
    input  wire logic                          int_sda_drive_low,
    output logic                               int_scl,
    output logic                               int_sda
);

    localparam int FW = psu_pkg::FAULT_W;
    localparam int IW = psu_pkg::IRQ_W;

    // stable-count filter after the synchroniser
    function automatic logic [psu_pkg::DEB_W-1:0] deb_next(
        input logic                       changed,
        input logic [psu_pkg::DEB_W-1:0]  cnt
    );
        if (changed)
            deb_next = cnt + 1'b1;
        else
            deb_next = '0;
    endfunction

    // synchronisers and debouncers
    logic [1:0]                  on_sync;
    logic [1:0]                  kill_sync;
    logic                        on_n_deb;
    logic                        kill_deb;
    logic [psu_pkg::DEB_W-1:0]   on_cnt;
    logic [psu_pkg::DEB_W-1:0]   kill_cnt;
    logic                        onoff_cycle;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            on_sync  <= 2'h3;
            kill_sync <= 2'h3;
        end else begin
            on_sync  <= {on_sync[0], main_output_on_n};
            kill_sync <= {kill_sync[0], hot_extract_disable};
        end
    end

    // filter hides bounce from the cycle detector
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            on_n_deb    <= 1'b1;
            kill_deb    <= 1'b1;
            on_cnt      <= '0;
            kill_cnt    <= '0;
            onoff_cycle <= 1'b0;
        end else begin
            on_cnt   <= deb_next(on_sync[1] != on_n_deb, on_cnt);
            kill_cnt <= deb_next(kill_sync[1] != kill_deb, kill_cnt);
            onoff_cycle <= 1'b0;
            if (on_cnt == psu_pkg::DEB_W'(psu_pkg::DEBOUNCE_CYC - 1)) begin
                on_n_deb    <= on_sync[1];
                on_cnt      <= '0;
                onoff_cycle <= 1'b1;
            end
            if (kill_cnt == psu_pkg::DEB_W'(psu_pkg::DEBOUNCE_CYC - 1)) begin
                kill_deb <= kill_sync[1];
                kill_cnt <= '0;
            end
        end
    end

    // ahb address phase capture
    psu_pkg::psu_ahb_phase_t   dphase;
    logic                      take;
    logic                      wr_en;

    assign take  = hsel && hready && htrans == psu_pkg::HTRANS_NONSEQ;
    assign wr_en = dphase.write;

    // registers
    logic [FW-1:0]  fault_latch;
    logic [FW-1:0]  alert_mask;
    logic [IW-1:0]  irq_status;
    logic [IW-1:0]  irq_mask;
    logic           clear_cmd;
    logic           input_lost;
    logic [FW-1:0]  fault_clr;
    logic [IW-1:0]  irq_event;
    logic           pgood_now;
    logic           pgood_prev;
    logic           input_prev;
    logic           alert_now;

    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = wr_en && dphase.addr == a;
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            dphase.write <= take && hwrite;
            dphase.read  <= take && !hwrite;
            dphase.addr  <= haddr[7:0];
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
        end
    end

    // read data set up in address phase: hrdata is a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            case (haddr[7:0])
                psu_pkg::REG_FAULT_STATUS: hrdata <= 32'(fault_latch);
                psu_pkg::REG_CONTROL:      hrdata <= 32'h0000_0000;
                psu_pkg::REG_ALERT_MASK:   hrdata <= 32'(alert_mask);
                psu_pkg::REG_PIN_STATE:
                    hrdata <= 32'({monitor, kill_deb, on_n_deb,
                                   main_output_enable, alert_n,
                                   output_power_good, input_good});
                psu_pkg::REG_IRQ_STATUS:   hrdata <= 32'(irq_status);
                psu_pkg::REG_IRQ_MASK:     hrdata <= 32'(irq_mask);
                psu_pkg::REG_BUS_ADDR:     hrdata <= 32'(bus_addr);
                default:                   hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // control writes
    assign clear_cmd =
        wr_hit(psu_pkg::REG_CONTROL) && hwdata[psu_pkg::CTRL_CLEAR_FAULTS];
    assign input_lost = !monitor.input_present;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alert_mask <= psu_pkg::ALERT_MASK_RST;
            irq_mask   <= psu_pkg::IRQ_MASK_RST;
        end else begin
            if (wr_en && dphase.addr == psu_pkg::REG_ALERT_MASK)
                alert_mask <= hwdata[FW-1:0];
            if (wr_en && dphase.addr == psu_pkg::REG_IRQ_MASK)
                irq_mask <= hwdata[IW-1:0];
        end
    end

    // clear: command, write-one, input loss, on/off cycle
    always_comb begin
        fault_clr = wr_hit(psu_pkg::REG_FAULT_STATUS) ? hwdata[FW-1:0] : '0;
        if (clear_cmd || input_lost || onoff_cycle)
            fault_clr = '1;
    end

    // a live condition re-sets its bit, so clears wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            fault_latch <= '0;
        else
            fault_latch <= fault_cond | (fault_latch & ~fault_clr);
    end

    assign alert_now = |(fault_latch & ~alert_mask);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alert_n   <= 1'b1;
            fault_led <= 1'b0;
        end else begin
            alert_n   <= !alert_now;
            fault_led <= alert_now;
        end
    end

    // power good and input good sequencing
    psu_pkg::psu_pg_state_t      pg_state;
    logic [psu_pkg::PREWARN_W-1:0] hold_cnt;

    assign pgood_now = monitor.main_valid && monitor.standby_valid;

    // output failure beats the hold-up window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pg_state          <= psu_pkg::PG_OFF;
            hold_cnt          <= '0;
            output_power_good <= 1'b0;
            input_good        <= 1'b0;
        end else begin
            input_good <= monitor.input_present;
            case (pg_state)
                psu_pkg::PG_OFF: begin
                    output_power_good <= 1'b0;
                    if (pgood_now && monitor.input_present) begin
                        pg_state          <= psu_pkg::PG_ON;
                        output_power_good <= 1'b1;
                    end
                end
                psu_pkg::PG_ON: begin
                    if (!pgood_now) begin
                        pg_state          <= psu_pkg::PG_OFF;
                        output_power_good <= 1'b0;
                    end else if (input_lost) begin
                        pg_state <= psu_pkg::PG_HOLD;
                        hold_cnt <= '0;
                    end
                end
                psu_pkg::PG_HOLD: begin
                    hold_cnt <= hold_cnt + 1'b1;
                    if (!pgood_now ||
                        hold_cnt == psu_pkg::PREWARN_W'(PREWARN_CYCLES)) begin
                        pg_state          <= psu_pkg::PG_OFF;
                        output_power_good <= 1'b0;
                    end
                end
                default: begin
                    pg_state          <= psu_pkg::PG_OFF;
                    output_power_good <= 1'b0;
                end
            endcase
        end
    end

    // open drain: drive low, release for high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            output_power_good_oe <= 1'b1;
        else
            output_power_good_oe <= !(pg_state == psu_pkg::PG_ON ||
                                      pg_state == psu_pkg::PG_HOLD);
    end

    // main output, presence and address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_output_enable <= 1'b0;
            present_n          <= 1'b0;
            bus_addr           <= psu_pkg::BUS_ADDR_BASE;
        end else begin
            main_output_enable <= !on_n_deb && !kill_deb
                                  && monitor.input_present;
            present_n          <= 1'b0;
            bus_addr <= psu_pkg::BUS_ADDR_BASE + 7'(addr_select);
        end
    end

    // unpowered: neither drive nor see the shared bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_oe  <= 1'b0;
            sda_oe  <= 1'b0;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            int_scl <= 1'b1;
            int_sda <= 1'b1;
        end else begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            scl_oe  <= monitor.module_powered && int_scl_drive_low;
            sda_oe  <= monitor.module_powered && int_sda_drive_low;
            int_scl <= monitor.module_powered ? scl_in : 1'b1;
            int_sda <= monitor.module_powered ? sda_in : 1'b1;
        end
    end

    // interrupt events
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pgood_prev <= 1'b0;
            input_prev <= 1'b0;
        end else begin
            pgood_prev <= output_power_good;
            input_prev <= monitor.input_present;
        end
    end

    always_comb begin
        irq_event                          = '0;
        irq_event[psu_pkg::IRQ_FAULT]       = |(fault_cond & ~fault_latch);
        irq_event[psu_pkg::IRQ_PGOOD_LOST]  = pgood_prev && !output_power_good;
        irq_event[psu_pkg::IRQ_INPUT_LOST]  = input_prev && input_lost;
        irq_event[psu_pkg::IRQ_ONOFF_CYCLE] = onoff_cycle;
    end

    // set wins over a same-cycle clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= '0;
            irq        <= 1'b0;
        end else begin
            irq_status <= irq_event |
                (irq_status & ~(hwdata[IW-1:0] &
                 {IW{wr_hit(psu_pkg::REG_IRQ_STATUS)}}));
            irq <= |(irq_status & irq_mask);
        end
    end

endmodule // psu_status_control

// *** psu_status_control_props.sv ***
// checker: port properties of the supply block
`timescale 1ns/1ps
module psu_status_control_props #(
    parameter int PREWARN_CYCLES = psu_pkg::PREWARN_CYC
) (
    // clock and reset
    input wire logic                  hclk,
    input wire logic                  hresetn,
    // monitors and host inputs
    input wire psu_pkg::psu_monitor_t monitor,
    input wire logic                  main_output_on_n,
    input wire logic                  hot_extract_disable,
    input wire logic [2:0]            addr_select,
    // status outputs
    input wire logic                  output_power_good,
    input wire logic                  input_good,
    input wire logic                  alert_n,
    input wire logic                  fault_led,
    input wire logic                  present_n,
    input wire logic                  main_output_enable,
    input wire logic [6:0]            bus_addr,
    input wire logic                  irq,
    // management bus
    input wire logic                  scl_oe,
    input wire logic                  sda_oe,
    input wire logic                  int_scl,
    input wire logic                  int_sda
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic        up;
    logic [15:0] kill_cnt;
    logic [15:0] off_cnt;
    logic [15:0] on_cnt;
    logic [15:0] ig_cnt;

    // run lengths of raw host levels and of input_good low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up       <= 1'b0;
            kill_cnt <= '0;
            off_cnt  <= '0;
            on_cnt   <= '0;
            ig_cnt   <= '0;
        end else begin
            up       <= 1'b1;
            kill_cnt <= hot_extract_disable ? kill_cnt + 16'h1 : '0;
            off_cnt  <= main_output_on_n ? off_cnt + 16'h1 : '0;
            on_cnt   <= (main_output_on_n | hot_extract_disable) ?
                        '0 : on_cnt + 16'h1;
            ig_cnt   <= input_good ? '0 : ig_cnt + 16'h1;
        end
    end

    property p_pgood_valid;
        output_power_good |->
            $past(monitor.main_valid & monitor.standby_valid);
    endproperty
    a_pgood_valid: assert property (p_pgood_valid)
        else $error("power good without valid outputs");

    property p_kill_off;
        kill_cnt > 16'h834 |-> !main_output_enable;
    endproperty
    a_kill_off: assert property (p_kill_off)
        else $error("main on with kill high");

    property p_onoff_off;
        off_cnt > 16'h834 |-> !main_output_enable;
    endproperty
    a_onoff_off: assert property (p_onoff_off)
        else $error("main on with on/off high");

    property p_on_rise;
        $rose(main_output_enable) |-> on_cnt >= 16'h7D0;
    endproperty
    a_on_rise: assert property (p_on_rise)
        else $error("main on before inputs settled");

    property p_led_follow;
        fault_led != alert_n;
    endproperty
    a_led_follow: assert property (p_led_follow)
        else $error("led differs from alert");

    property p_present;
        present_n == 1'b0;
    endproperty
    a_present: assert property (p_present)
        else $error("presence output not low");

    property p_addr;
        up |-> bus_addr == psu_pkg::BUS_ADDR_BASE + $past(addr_select);
    endproperty
    a_addr: assert property (p_addr)
        else $error("bus address wrong");

    property p_isolate;
        up && $past(!monitor.module_powered) |->
            !scl_oe && !sda_oe && int_scl && int_sda;
    endproperty
    a_isolate: assert property (p_isolate)
        else $error("bus not isolated");

    property p_prewarn;
        $fell(output_power_good) &&
            $past(monitor.main_valid & monitor.standby_valid) |->
            ig_cnt >= PREWARN_CYCLES;
    endproperty
    a_prewarn: assert property (p_prewarn)
        else $error("no input good prewarning");

    c_main_on: cover property ($rose(main_output_enable));
    c_alert: cover property ($fell(alert_n));
    c_prewarn: cover property ($fell(output_power_good) && !input_good);
    c_irq: cover property ($rose(irq));
endmodule // psu_status_control_props

bind psu_status_control psu_status_control_props #(
    .PREWARN_CYCLES(PREWARN_CYCLES)
) i_props (
    .hclk, .hresetn, .monitor, .main_output_on_n, .hot_extract_disable,
    .addr_select, .output_power_good, .input_good, .alert_n, .fault_led,
    .present_n, .main_output_enable, .bus_addr, .irq, .scl_oe, .sda_oe,
    .int_scl, .int_sda
);

// *** psu_status_control_signals_test.sv ***
// testbench: supply status and control signalling
`timescale 1ns/1ps
module psu_status_control_signals_test;
    localparam int PW = 20;
    logic                  hclk = 1'b0;
    logic                  hresetn = 1'b0;
    logic                  hsel = 1'b0;
    logic                  hwrite = 1'b0;
    logic [31:0]           haddr = 32'h0;
    logic [31:0]           hwdata = 32'h0;
    logic [1:0]            htrans = psu_pkg::HTRANS_IDLE;
    logic [2:0]            hsize = 3'h2;
    psu_pkg::psu_monitor_t monitor = '0;
    logic [7:0]            fault_cond = 8'h00;
    logic                  want_on = 1'b0;
    logic                  seated = 1'b0;
    logic [2:0]            sel = 3'h0;
    logic                  host_scl_low = 1'b0;
    logic                  int_scl_drive_low = 1'b0;
    logic                  int_sda_drive_low = 1'b0;
    wire logic             hready;
    logic                  hreadyout, hresp, irq, input_good, alert_n;
    logic                  output_power_good, output_power_good_oe;
    logic                  fault_led, present_n, main_output_enable;
    logic                  main_output_on_n, hot_extract_disable;
    logic                  scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
    logic                  int_scl, int_sda, sees_module;
    logic [31:0]           hrdata;
    logic [6:0]            bus_addr;
    logic [2:0]            addr_select;
    int                    error_cnt = 0;
    int                    compares = 0;
    int                    cyc = 0;

    assign hready = hreadyout;
    always #25 hclk = ~hclk;

    psu_status_control #(.PREWARN_CYCLES(PW)) i_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq, .monitor,
        .fault_cond, .main_output_on_n, .hot_extract_disable,
        .addr_select, .output_power_good, .output_power_good_oe,
        .input_good, .alert_n, .fault_led, .present_n,
        .main_output_enable, .bus_addr, .scl_in, .scl_out, .scl_oe,
        .sda_in, .sda_out, .sda_oe, .int_scl_drive_low,
        .int_sda_drive_low, .int_scl, .int_sda
    );
    psu_host_model i_host (
        .want_on, .seated, .sel, .host_scl_low, .present_n, .scl_out,
        .scl_oe, .sda_out, .sda_oe, .main_output_on_n,
        .hot_extract_disable, .addr_select, .scl_in, .sda_in, .sees_module
    );

    function automatic logic [31:0] exp_addr(input int s);
        return {25'h0, psu_pkg::BUS_ADDR_BASE + 7'(s)};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // single transfer, waits on hready
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= psu_pkg::HTRANS_NONSEQ;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= psu_pkg::HTRANS_IDLE;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, e);
    endtask
    task automatic pulse(input logic [7:0] m);
        fault_cond <= m;
        tick(1);
        fault_cond <= 8'h00;
        tick(3);
    endtask
    task automatic conclude();
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            conclude();
        end
    end

    initial begin
        int b, b2, n;
        void'($urandom(32'hF03B));
        b  = $urandom_range(7, 0);
        b2 = (b + 1 + $urandom_range(6, 0)) % 8;
        tick(12);
        chk({alert_n, fault_led, present_n, main_output_enable}, 32'h8);
        hresetn <= 1'b1;
        tick(1);
        chk(sees_module, 32'h1);
        rdchk(psu_pkg::REG_ALERT_MASK, 32'h0);
        wr(8'h1C, 32'hFFFF);
        rdchk(8'h1C, 32'h0);
        wr(psu_pkg::REG_BUS_ADDR, 32'h7F);
        for (int i = 0; i < 8; i++) begin
            sel <= 3'(i);
            tick(3);
            chk({25'h0, bus_addr}, exp_addr(i));
            rdchk(psu_pkg::REG_BUS_ADDR, exp_addr(i));
        end
        monitor <= 4'hF;
        tick(3);
        chk(output_power_good, 32'h1);
        chk({hresp, output_power_good_oe}, 32'h0);
        for (int k = 0; k < 2; k++) begin
            monitor <= k ? 4'hB : 4'h7;
            tick(3);
            chk(output_power_good, 32'h0);
            monitor <= 4'hF;
            tick(3);
        end
        wr(psu_pkg::REG_IRQ_STATUS, 32'hF);
        wr(psu_pkg::REG_IRQ_MASK, 32'h1);
        tick(2);
        chk(irq, 32'h0);
        pulse(8'h1 << b);
        chk(alert_n, 32'h0);
        chk(fault_led, 32'h1);
        chk(irq, 32'h1);
        rdchk(psu_pkg::REG_FAULT_STATUS, 8'h1 << b);
        wr(psu_pkg::REG_IRQ_STATUS, 32'h1);
        tick(2);
        chk(irq, 32'h0);
        // live condition survives a clear
        fault_cond <= 8'h1 << b;
        wr(psu_pkg::REG_FAULT_STATUS, 8'h1 << b);
        tick(2);
        chk(alert_n, 32'h0);
        fault_cond <= 8'h00;
        wr(psu_pkg::REG_FAULT_STATUS, 8'h1 << b);
        tick(2);
        chk(alert_n, 32'h1);
        pulse(8'h1 << b2);
        wr(psu_pkg::REG_CONTROL, 32'h1);
        tick(2);
        chk(alert_n, 32'h1);
        wr(psu_pkg::REG_ALERT_MASK, 8'h1 << b);
        rdchk(psu_pkg::REG_ALERT_MASK, 8'h1 << b);
        pulse(8'h1 << b);
        chk(alert_n, 32'h1);
        pulse(8'h1 << b2);
        chk(alert_n, 32'h0);
        wr(psu_pkg::REG_FAULT_STATUS, 32'hFF);
        wr(psu_pkg::REG_ALERT_MASK, 32'h0);
        pulse(8'h1 << b);
        monitor.input_present <= 1'b0;
        n = 0;
        while (input_good !== 1'b0 && n < 10) begin
            tick(1);
            n++;
        end
        n = 0;
        while (output_power_good === 1'b1 && n < 500) begin
            tick(1);
            n++;
        end
        chk(n >= PW && n < 60, 32'h1);
        chk(alert_n, 32'h1);
        monitor <= 4'hF;
        want_on <= 1'b1;
        seated  <= 1'b1;
        tick(2010);
        chk(main_output_enable, 32'h1);
        // glitch shorter than debounce
        want_on <= 1'b0;
        tick(100);
        want_on <= 1'b1;
        tick(2010);
        chk(main_output_enable, 32'h1);
        pulse(8'h1 << b);
        want_on <= 1'b0;
        tick(2010);
        chk(main_output_enable, 32'h0);
        chk(alert_n, 32'h1);
        want_on <= 1'b1;
        tick(2010);
        seated <= 1'b0;
        tick(2010);
        chk(main_output_enable, 32'h0);
        host_scl_low      <= 1'b1;
        monitor           <= 4'hE;
        int_scl_drive_low <= 1'b1;
        int_sda_drive_low <= 1'b1;
        tick(3);
        chk({scl_oe, sda_oe, int_scl, int_sda}, 32'h3);
        monitor      <= 4'hF;
        host_scl_low <= 1'b0;
        tick(3);
        chk({scl_oe, sda_oe, int_scl, int_sda}, 32'hC);
        conclude();
    end
endmodule // psu_status_control_signals_test
